// file: rtl/cal_skip_fail_status_regs.v
// skipped-alignment and extended-failure status register groups with command port
// What this block does
// - skip condition read returns set bits
// - enabled skip events drive parent bit 11
// - events latch until read, read clears
// - events set only through a transition filter
// - fall filter catches one-to-zero changes
// - rise filter catches zero-to-one changes
// - enabled failure events drive parent bit 9
// - failure condition tracks live, no latching
// - failure event read returns latched bits
// - failure group has own edge filters
`default_nettype none
`include "cal_status_map.vh"

module cal_skip_fail_status_regs (
    // clock and reset
    input  wire                    mclk,
    input  wire                    reset_n,
    // live condition inputs
    input  wire [`STAT_WIDTH-1:0]  skip_cond_in,
    input  wire [`STAT_WIDTH-1:0]  fail_cond_in,
    // command port
    input  wire                    cmd_valid,
    input  wire                    cmd_write,
    input  wire [`SEL_WIDTH-1:0]   cmd_sel,
    input  wire [`STAT_WIDTH-1:0]  cmd_wdata,
    // response
    output reg                     rsp_valid,
    output reg  [`STAT_WIDTH-1:0]  rsp_data,
    output reg                     rsp_error,
    // parent calibration status contribution
    output wire [`PARENT_WIDTH-1:0] cal_summary
);

    wire                   wr;
    wire                   rd;
    wire [`STAT_WIDTH-1:0] skip_condition;
    wire [`STAT_WIDTH-1:0] skip_event_latch;
    wire [`STAT_WIDTH-1:0] skip_enable_mask;
    wire [`STAT_WIDTH-1:0] skip_rise_filter;
    wire [`STAT_WIDTH-1:0] skip_fall_filter;
    wire                   skip_summary;
    wire [`STAT_WIDTH-1:0] fail_condition;
    wire [`STAT_WIDTH-1:0] fail_event_latch;
    wire [`STAT_WIDTH-1:0] fail_enable_mask;
    wire [`STAT_WIDTH-1:0] fail_rise_filter;
    wire [`STAT_WIDTH-1:0] fail_fall_filter;
    wire                   fail_summary;
    reg  [`STAT_WIDTH-1:0] next_rsp_data;
    reg                    next_rsp_error;

    // command qualifiers; host keeps writes within fifteen bits
    assign wr = cmd_valid & cmd_write;
    assign rd = cmd_valid & ~cmd_write;

    // skipped-alignment group
    status_group u_skip (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .cond_in     (skip_cond_in),
        .wdata       (cmd_wdata),
        .wr_enable   (wr && cmd_sel == `SEL_SKIP_ENABLE),
        .wr_rise     (wr && cmd_sel == `SEL_SKIP_RISE),
        .wr_fall     (wr && cmd_sel == `SEL_SKIP_FALL),
        .rd_event    (rd && cmd_sel == `SEL_SKIP_EVENT),
        .condition   (skip_condition),
        .event_latch (skip_event_latch),
        .enable_mask (skip_enable_mask),
        .rise_filter (skip_rise_filter),
        .fall_filter (skip_fall_filter),
        .summary     (skip_summary)
    );

    // extended-failure group
    status_group u_fail (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .cond_in     (fail_cond_in),
        .wdata       (cmd_wdata),
        .wr_enable   (wr && cmd_sel == `SEL_FAIL_ENABLE),
        .wr_rise     (wr && cmd_sel == `SEL_FAIL_RISE),
        .wr_fall     (wr && cmd_sel == `SEL_FAIL_FALL),
        .rd_event    (rd && cmd_sel == `SEL_FAIL_EVENT),
        .condition   (fail_condition),
        .event_latch (fail_event_latch),
        .enable_mask (fail_enable_mask),
        .rise_filter (fail_rise_filter),
        .fall_filter (fail_fall_filter),
        .summary     (fail_summary)
    );

    // parent summary bits, all other positions zero
    assign cal_summary = {{(`PARENT_WIDTH-1-`SKIP_SUMMARY_BIT){1'b0}},
                          skip_summary,
                          1'b0,
                          fail_summary,
                          {`FAIL_SUMMARY_BIT{1'b0}}};

    // read mux and access check
    always @* begin
        next_rsp_data  = {`STAT_WIDTH{1'b0}};
        next_rsp_error = 1'b0;
        case (cmd_sel)
            `SEL_SKIP_CONDITION: begin
                next_rsp_data  = cmd_write ? {`STAT_WIDTH{1'b0}} : skip_condition;
                next_rsp_error = cmd_write;
            end
            `SEL_SKIP_EVENT: begin
                next_rsp_data  = cmd_write ? {`STAT_WIDTH{1'b0}} : skip_event_latch;
                next_rsp_error = cmd_write;
            end
            `SEL_SKIP_ENABLE: begin
                next_rsp_data = cmd_write ? {`STAT_WIDTH{1'b0}} : skip_enable_mask;
            end
            `SEL_SKIP_RISE: begin
                next_rsp_data = cmd_write ? {`STAT_WIDTH{1'b0}} : skip_rise_filter;
            end
            `SEL_SKIP_FALL: begin
                next_rsp_data = cmd_write ? {`STAT_WIDTH{1'b0}} : skip_fall_filter;
            end
            `SEL_FAIL_CONDITION: begin
                next_rsp_data  = cmd_write ? {`STAT_WIDTH{1'b0}} : fail_condition;
                next_rsp_error = cmd_write;
            end
            `SEL_FAIL_EVENT: begin
                next_rsp_data  = cmd_write ? {`STAT_WIDTH{1'b0}} : fail_event_latch;
                next_rsp_error = cmd_write;
            end
            `SEL_FAIL_ENABLE: begin
                next_rsp_data = cmd_write ? {`STAT_WIDTH{1'b0}} : fail_enable_mask;
            end
            `SEL_FAIL_RISE: begin
                next_rsp_data = cmd_write ? {`STAT_WIDTH{1'b0}} : fail_rise_filter;
            end
            `SEL_FAIL_FALL: begin
                next_rsp_data = cmd_write ? {`STAT_WIDTH{1'b0}} : fail_fall_filter;
            end
            default: begin
                next_rsp_error = 1'b1;                                 // unmapped select
            end
        endcase
    end

    // registered response, one cycle after the command
    always @(posedge mclk) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_data  <= {`STAT_WIDTH{1'b0}};
            rsp_error <= 1'b0;
        end else begin
            rsp_valid <= cmd_valid;
            if (cmd_valid) begin
                rsp_data  <= next_rsp_data;
                rsp_error <= next_rsp_error;
            end
        end
    end

endmodule // cal_skip_fail_status_regs
`default_nettype wire

// file: rtl/cal_status_map.vh
// command codes, field widths, reset values and summary positions for the calibration status groups
`ifndef CAL_STATUS_MAP_VH
`define CAL_STATUS_MAP_VH

// width of every status register in both groups
`define STAT_WIDTH         15
// width of the parent calibration status word
`define PARENT_WIDTH       16
// width of the register select code
`define SEL_WIDTH          4

// register select codes, skipped-alignment group
`define SEL_SKIP_CONDITION 4'h0
`define SEL_SKIP_EVENT     4'h1
`define SEL_SKIP_ENABLE    4'h2
`define SEL_SKIP_RISE      4'h3
`define SEL_SKIP_FALL      4'h4
// register select codes, extended-failure group
`define SEL_FAIL_CONDITION 4'h5
`define SEL_FAIL_EVENT     4'h6
`define SEL_FAIL_ENABLE    4'h7
`define SEL_FAIL_RISE      4'h8
`define SEL_FAIL_FALL      4'h9

// reset (preset) values
`define RST_CONDITION      15'h0000
`define RST_EVENT          15'h0000
`define RST_ENABLE         15'h7fff
`define RST_RISE           15'h7fff
`define RST_FALL           15'h0000

// summary bit positions in the parent calibration status word
`define SKIP_SUMMARY_BIT   11
`define FAIL_SUMMARY_BIT   9

`endif

// file: rtl/status_group.v
// one status group: condition, edge filters, latched events, enable mask and summary
`default_nettype none
`include "cal_status_map.vh"

module status_group (
    // clock and reset
    input  wire                    mclk,
    input  wire                    reset_n,
    // live condition inputs
    input  wire [`STAT_WIDTH-1:0]  cond_in,
    // register writes and event read
    input  wire [`STAT_WIDTH-1:0]  wdata,
    input  wire                    wr_enable,
    input  wire                    wr_rise,
    input  wire                    wr_fall,
    input  wire                    rd_event,
    // register contents
    output reg  [`STAT_WIDTH-1:0]  condition,
    output reg  [`STAT_WIDTH-1:0]  event_latch,
    output reg  [`STAT_WIDTH-1:0]  enable_mask,
    output reg  [`STAT_WIDTH-1:0]  rise_filter,
    output reg  [`STAT_WIDTH-1:0]  fall_filter,
    // summary for the parent register
    output reg                     summary
);

    wire [`STAT_WIDTH-1:0] rise_edge;
    wire [`STAT_WIDTH-1:0] fall_edge;
    wire [`STAT_WIDTH-1:0] event_set;
    reg  [`STAT_WIDTH-1:0] next_event;
    reg  [`STAT_WIDTH-1:0] next_enable;

    // transitions of each condition bit against its last sampled value
    assign rise_edge = cond_in & ~condition;
    assign fall_edge = ~cond_in & condition;
    assign event_set = (rise_edge & rise_filter) | (fall_edge & fall_filter);

    // next event and mask values; a new event wins over the read clear
    always @* begin
        next_event  = (rd_event ? {`STAT_WIDTH{1'b0}} : event_latch) | event_set;
        next_enable = wr_enable ? wdata : enable_mask;
    end

    // register state
    always @(posedge mclk) begin
        if (!reset_n) begin
            condition   <= `RST_CONDITION;
            event_latch <= `RST_EVENT;
            enable_mask <= `RST_ENABLE;
            rise_filter <= `RST_RISE;
            fall_filter <= `RST_FALL;
            summary     <= 1'b0;
        end else begin
            condition   <= cond_in;
            event_latch <= next_event;
            enable_mask <= next_enable;
            summary     <= |(next_event & next_enable);
            if (wr_rise) begin
                rise_filter <= wdata;
            end
            if (wr_fall) begin
                fall_filter <= wdata;
            end
        end
    end

endmodule // status_group
`default_nettype wire

// file: bench/cal_status_checker.sv
// port-level assertions for the calibration status register block
`default_nettype none
`include "cal_status_map.vh"
module cal_status_checker (
    // clock and reset
    input wire logic                      mclk,
    input wire logic                      reset_n,
    // conditions and commands
    input wire logic [`STAT_WIDTH-1:0]    skip_cond_in,
    input wire logic [`STAT_WIDTH-1:0]    fail_cond_in,
    input wire logic                      cmd_valid,
    input wire logic                      cmd_write,
    input wire logic [`SEL_WIDTH-1:0]     cmd_sel,
    input wire logic [`STAT_WIDTH-1:0]    cmd_wdata,
    // responses and summary
    input wire logic                      rsp_valid,
    input wire logic [`STAT_WIDTH-1:0]    rsp_data,
    input wire logic                      rsp_error,
    input wire logic [`PARENT_WIDTH-1:0]  cal_summary
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // command decodes
    wire logic rd = cmd_valid && !cmd_write;
    wire logic bad = cmd_valid && (cmd_sel > 4'h9 || cmd_write && cmd_sel % 5 < 2);
    // properties
    property p_answer; cmd_valid |=> rsp_valid; endproperty
    property p_skip_cond; rd && cmd_sel == 4'h0 && $past(reset_n) |=> rsp_data == $past(skip_cond_in, 2); endproperty
    property p_fail_cond; rd && cmd_sel == 4'h5 && $past(reset_n) |=> rsp_data == $past(fail_cond_in, 2); endproperty
    property p_parent; (cal_summary & 16'hf5ff) == 16'h0; endproperty
    property p_skip_rise;
        $rose(cal_summary[11]) |-> $past(skip_cond_in) != $past(skip_cond_in, 2) || !$past(reset_n, 2)
            || $past(cmd_valid && cmd_write && cmd_sel == 4'h2);
    endproperty
    property p_skip_fall; $fell(cal_summary[11]) |-> $past(cmd_valid && cmd_sel inside {4'h1, 4'h2}); endproperty
    property p_fail_fall; $fell(cal_summary[9]) |-> $past(cmd_valid && cmd_sel inside {4'h6, 4'h7}); endproperty
    property p_refuse; bad |=> rsp_error && rsp_data == 15'h0; endproperty
    property p_clear;
        rd && cmd_sel == 4'h6 && $stable(fail_cond_in) && $past(reset_n) ##1 rd && cmd_sel == 4'h6 |=> rsp_data == 15'h0;
    endproperty
    // assertions
    a_answer: assert property (p_answer) else $error("command not answered");
    a_skip_cond: assert property (p_skip_cond) else $error("skip condition read wrong");
    a_fail_cond: assert property (p_fail_cond) else $error("fail condition read wrong");
    a_parent: assert property (p_parent) else $error("unused parent bit set");
    a_skip_rise: assert property (p_skip_rise) else $error("skip summary rose without cause");
    a_skip_fall: assert property (p_skip_fall) else $error("skip summary fell without cause");
    a_fail_fall: assert property (p_fail_fall) else $error("fail summary fell without cause");
    a_refuse: assert property (p_refuse) else $error("bad command not refused");
    a_clear: assert property (p_clear) else $error("event read did not clear");
    // main scenarios
    c_event_read: cover property (rd && cmd_sel == 4'h1);
    c_fail_summary: cover property ($rose(cal_summary[9]));
    c_refused: cover property (bad);
endmodule // cal_status_checker
bind cal_skip_fail_status_regs cal_status_checker cal_status_checker_inst (.mclk(mclk), .reset_n(reset_n),
    .skip_cond_in(skip_cond_in), .fail_cond_in(fail_cond_in), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .cal_summary(cal_summary));
`default_nettype wire

// file: bench/test_cal_skip_fail_status_regs.sv
// self-checking bench for the calibration status register block
`default_nettype none
`include "cal_status_map.vh"
module test_cal_skip_fail_status_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // design signals
    logic                      mclk = 1'b0;
    logic                      reset_n = 1'b0;
    logic [`STAT_WIDTH-1:0]    skip_cond_in = 15'h0;
    logic [`STAT_WIDTH-1:0]    fail_cond_in = 15'h0;
    logic                      cmd_valid = 1'b0;
    logic                      cmd_write = 1'b0;
    logic [`SEL_WIDTH-1:0]     cmd_sel = 4'h0;
    logic [`STAT_WIDTH-1:0]    cmd_wdata = 15'h0;
    logic                      rsp_valid;
    logic [`STAT_WIDTH-1:0]    rsp_data;
    logic                      rsp_error;
    logic [`PARENT_WIDTH-1:0]  cal_summary;
    // bench state
    logic [15:0]               exp_q[$];
    logic [14:0]               r;
    int                        mismatches = 0;
    int                        n_compared = 0;
    cal_skip_fail_status_regs cal_skip_fail_status_regs_inst (.mclk(mclk), .reset_n(reset_n),
        .skip_cond_in(skip_cond_in), .fail_cond_in(fail_cond_in), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_error(rsp_error), .cal_summary(cal_summary));
    // clock
    always #5 mclk = ~mclk;
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one command; strobe stays up so commands can run back to back
    task automatic op(input logic w, input logic [3:0] s, input logic [14:0] d, input logic [15:0] e);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_sel = s;
        cmd_wdata = d;
        exp_q.push_back(e);
        @(posedge mclk);
        #1;
    endtask
    // drop the strobe and let edges pass
    task automatic idle(input int n);
        cmd_valid = 1'b0;
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // report and end the run
    task automatic summarize;
        if (exp_q.size() != 0) mismatches++;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // response watcher: oldest note against each response
    always @(posedge mclk) begin
        if (rsp_valid === 1'b1) chk({rsp_error, rsp_data}, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
    end
    // main sequence
    initial begin
        r = 15'($urandom(32'h1f73));
        repeat (4) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        // presets of every register and refused selects
        for (int s = 0; s < 16; s++) begin
            op(1'b0, s[3:0], 15'h0, s > 9 ? 16'h8000 : (s % 5 inside {2, 3}) ? 16'h7fff : 16'h0);
        end
        op(1'b1, 4'h0, 15'h1, 16'h8000);
        r = 15'($urandom()) | 15'h1;
        op(1'b1, 4'h3, 15'h0, 16'h0);
        op(1'b1, 4'h4, 15'h7fff, 16'h0);
        // rising conditions: skip filtered out, fail caught by preset rise filter
        skip_cond_in = r;
        fail_cond_in = r;
        idle(2);
        chk(cal_summary, 16'h0200);
        op(1'b0, 4'h0, 15'h0, {1'b0, r});
        op(1'b0, 4'h5, 15'h0, {1'b0, r});
        op(1'b0, 4'h1, 15'h0, 16'h0);
        op(1'b0, 4'h6, 15'h0, {1'b0, r});
        op(1'b0, 4'h6, 15'h0, 16'h0);
        chk(cal_summary, 16'h0);
        // falling conditions: skip fall filter set, fail fall filter clear
        skip_cond_in = 15'h0;
        fail_cond_in = 15'h0;
        idle(1);
        chk(cal_summary, 16'h0800);
        op(1'b1, 4'h2, ~r, 16'h0);
        chk(cal_summary, 16'h0);
        op(1'b1, 4'h2, 15'h7fff, 16'h0);
        chk(cal_summary, 16'h0800);
        op(1'b0, 4'h1, 15'h0, {1'b0, r});
        op(1'b0, 4'h6, 15'h0, 16'h0);
        chk(cal_summary, 16'h0);
        // failure group's own filters: rise off, fall on
        op(1'b1, 4'h8, 15'h0, 16'h0);
        op(1'b1, 4'h9, 15'h7fff, 16'h0);
        fail_cond_in = r;
        idle(1);
        chk(cal_summary, 16'h0);
        fail_cond_in = 15'h0;
        idle(1);
        chk(cal_summary, 16'h0200);
        op(1'b0, 4'h6, 15'h0, {1'b0, r});
        op(1'b0, 4'h8, 15'h0, 16'h0);
        op(1'b0, 4'h9, 15'h0, 16'h7fff);
        chk(cal_summary, 16'h0);
        idle(2);
        summarize();
    end
endmodule // test_cal_skip_fail_status_regs
`default_nettype wire
